// [verilog/hpp_pkg.sv]
// package for the host processor port: widths, modes, carriers and reset values
package hpp_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [11:0] ADDR_RST = 12'h000;

  typedef enum logic [1:0] {
    HPP_MODE_COMBINED = 2'h1,
    HPP_MODE_SPLIT    = 2'h2
  } hpp_mode_t;

  typedef enum logic [2:0] {
    HPP_IDLE  = 3'h1,
    HPP_READ  = 3'h2,
    HPP_WRITE = 3'h4
  } hpp_state_t;

  // processor-side pins, sampled as synchronous to clk
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic        cs_n;
    logic        rnw_or_wr_n;
    logic        oe_or_rd_n;
  } hpp_pins_t;

  // internal access toward the register/memory space
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [15:0] wdata;
  } hpp_req_t;
endpackage

// [verilog/hpp_decode.sv]
// strobe decoder: turns either strobe convention into read/write indications
`timescale 1ns/100ps
module hpp_decode
  import hpp_pkg::*;
(
  // mode and pins
  input  wire hpp_mode_t mode,
  input  wire hpp_pins_t pins,
  // decoded access
  output logic           rd_act,
  output logic           wr_act
);
  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (!pins.cs_n) begin
      if (mode == HPP_MODE_COMBINED) begin
        // output enable is assumed grounded, so it is not consulted
        rd_act = pins.rnw_or_wr_n;
        wr_act = !pins.rnw_or_wr_n;
      end else begin
        // both strobes low: the write wins, so the drivers never fight the processor
        rd_act = !pins.oe_or_rd_n && pins.rnw_or_wr_n;
        wr_act = !pins.rnw_or_wr_n;
      end
    end
  end
endmodule

// [verilog/hpp_port.sv]
// host processor port: parallel bus slave in front of the internal register/memory space
`timescale 1ns/100ps
// Notes on behaviour
// - a 12-bit address picks the internal register or memory location accessed
// - 16-bit two-way data bus: driven on reads, sampled on writes
// - combined mode: direction low writes, high reads and returns addressed data
// - split mode: active-low write strobe stores bus data at the address
// - split mode: active-low read strobe puts the addressed contents on the bus
// - chip select high: all other bus inputs ignored; low: accepted
// - open-drain interrupt pulled low while any internal condition is pending
module hpp_port
  import hpp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // strobe convention
  input  wire hpp_mode_t   mode,
  // processor pins
  input  wire logic [11:0] up_addr,
  input  wire logic [15:0] up_data_in,
  output logic      [15:0] up_data_out,
  output logic             up_data_oe,
  input  wire logic        up_cs_n,
  input  wire logic        up_rnw_or_wr_n,
  input  wire logic        up_oe_or_rd_n,
  output logic             up_irq_out,
  output logic             up_irq_oe,
  // internal register/memory space
  output hpp_req_t         core_req,
  input  wire logic [15:0] core_rdata,
  input  wire logic        core_irq_pend
);
  typedef struct packed {
    hpp_state_t  st;
    logic [15:0] dout;
    logic        doe;
    logic        irq_oe;
    hpp_req_t    req;
  } hpp_reg_t;

  hpp_reg_t  s_ff;
  hpp_reg_t  nxt_s;
  hpp_pins_t pins;
  logic      rd_act;
  logic      wr_act;

  assign pins = '{addr: up_addr, wdata: up_data_in, cs_n: up_cs_n,
                  rnw_or_wr_n: up_rnw_or_wr_n, oe_or_rd_n: up_oe_or_rd_n};

  hpp_decode u_decode (
    .mode   (mode),
    .pins   (pins),
    .rd_act (rd_act),
    .wr_act (wr_act)
  );

  // timing seen from the processor bus, counted in clk edges after the edge that
  // first samples a strobe with chip select low:
  //   write: core_req.wr pulses one cycle later; a held strobe adds nothing, so a
  //          second write needs the strobe released for at least one edge
  //   read:  core_req.rd rises one cycle later and stays while the strobe stays;
  //          the data drivers turn on one cycle after that with the word fetched
  //          for the address of the previous cycle
  //   end:   the drivers turn off one cycle after the strobe or chip select goes
  // the one-cycle lag of the drivers is the price of registered outputs; a
  // processor that turns the bus around faster must leave a dead cycle itself

  always_comb begin
    nxt_s = s_ff;
    nxt_s.req.rd = 1'b0;
    nxt_s.req.wr = 1'b0;
    // the level is fixed low; only the enable toggles, as an open drain needs
    nxt_s.irq_oe = core_irq_pend;
    case (s_ff.st)
      HPP_IDLE: begin
        nxt_s.doe = 1'b0;
        if (wr_act) begin
          // one write per strobe, however long the strobe is held
          nxt_s.st        = HPP_WRITE;
          nxt_s.req.wr    = 1'b1;
          nxt_s.req.addr  = pins.addr;
          nxt_s.req.wdata = pins.wdata;
        end else if (rd_act) begin
          nxt_s.st       = HPP_READ;
          nxt_s.req.rd   = 1'b1;
          nxt_s.req.addr = pins.addr;
        end
      end
      HPP_READ: begin
        if (rd_act) begin
          // address follows the bus so a changed address is re-read
          nxt_s.req.rd   = 1'b1;
          nxt_s.req.addr = pins.addr;
          nxt_s.dout     = core_rdata;
          nxt_s.doe      = 1'b1;
        end else begin
          nxt_s.st  = HPP_IDLE;
          nxt_s.doe = 1'b0;
        end
      end
      HPP_WRITE: begin
        nxt_s.doe = 1'b0;
        if (!wr_act) begin
          nxt_s.st = HPP_IDLE;
        end
      end
      default: begin
        nxt_s.st  = HPP_IDLE;
        nxt_s.doe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '{st: HPP_IDLE, dout: DATA_RST, doe: 1'b0, irq_oe: 1'b0,
                req: '{rd: 1'b0, wr: 1'b0, addr: ADDR_RST, wdata: DATA_RST}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign up_data_out = s_ff.dout;
  assign up_data_oe  = s_ff.doe;
  assign up_irq_out  = 1'b0;
  assign up_irq_oe   = s_ff.irq_oe;
  assign core_req    = s_ff.req;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  drive_gate_a: assert property (up_data_oe |-> $past(rd_act))
    else $error("data bus driven without select and read");
  cs_ignore_a: assert property (up_cs_n |=> !core_req.rd && !core_req.wr)
    else $error("access taken while chip select high");
  irq_follow_a: assert property (core_irq_pend |=> up_irq_oe && !up_irq_out)
    else $error("interrupt not pulled low while pending");
  irq_release_a: assert property (!core_irq_pend |=> !up_irq_oe)
    else $error("interrupt not released");
  wr_once_a: assert property (core_req.wr |=> !core_req.wr)
    else $error("write strobe repeated");
  wr_addr_a: assert property (core_req.wr |-> core_req.addr == $past(up_addr)
                              && core_req.wdata == $past(up_data_in))
    else $error("write address or data not captured");
  comb_wr_a: assert property (mode == HPP_MODE_COMBINED && !up_cs_n && !up_rnw_or_wr_n
                              && s_ff.st == HPP_IDLE |=> core_req.wr)
    else $error("combined write not taken");
  split_rd_a: assert property (mode == HPP_MODE_SPLIT && !up_cs_n && !up_oe_or_rd_n
                               && up_rnw_or_wr_n && s_ff.st == HPP_IDLE
                               ##1 rd_act |=> up_data_oe)
    else $error("split read did not drive bus");
  rd_data_a: assert property (up_data_oe && $past(up_data_oe) |-> up_data_out == $past(core_rdata))
    else $error("read data not from addressed location");

  // decoder level: chip select high must gate both indications off
  cs_gate_a: assert property (up_cs_n |-> !rd_act && !wr_act)
    else $error("strobe decoded while chip select high");

  // both strobes low is a processor error; the write must win
  split_prio_a: assert property (
    mode == HPP_MODE_SPLIT && !up_cs_n && !up_rnw_or_wr_n && !up_oe_or_rd_n |-> wr_act && !rd_act)
    else $error("split mode read taken over a write strobe");

  split_wr_a: assert property (
    mode == HPP_MODE_SPLIT && !up_cs_n && !up_rnw_or_wr_n && s_ff.st == HPP_IDLE |=> core_req.wr)
    else $error("split write not taken");

  comb_rd_a: assert property (
    mode == HPP_MODE_COMBINED && !up_cs_n && up_rnw_or_wr_n && s_ff.st == HPP_IDLE |=> core_req.rd)
    else $error("combined read not taken");

  // the output enable input plays no part in combined mode
  comb_oe_a: assert property (
    mode == HPP_MODE_COMBINED |-> rd_act == (!up_cs_n && up_rnw_or_wr_n))
    else $error("combined read decode depends on output enable");

  wr_src_a: assert property (
    core_req.wr |-> $past(wr_act) && $past(s_ff.st) == HPP_IDLE)
    else $error("write issued without a fresh write strobe");

  wr_state_a: assert property (core_req.wr |-> s_ff.st == HPP_WRITE)
    else $error("write issued outside the write state");

  rd_src_a: assert property (core_req.rd |-> $past(rd_act))
    else $error("read issued without a read strobe");

  // a read held across an address change must follow the new address
  rd_follow_a: assert property (
    s_ff.st == HPP_READ && rd_act |=> core_req.rd && core_req.addr == $past(up_addr))
    else $error("held read lost the bus address");

  excl_a: assert property (!(core_req.rd && core_req.wr))
    else $error("read and write issued together");

  oe_drop_a: assert property (!rd_act |=> !up_data_oe)
    else $error("data drivers stayed on after the read ended");

  oe_state_a: assert property (up_data_oe |-> s_ff.st == HPP_READ)
    else $error("data drivers on outside a read");

  // a stray state code only reaches the default branch of the case, which returns to HPP_IDLE with the drivers off
  state_hot_a: assert property ($onehot(s_ff.st))
    else $error("state register not one-hot");

  // checked through reset as well, so the default disable is overridden here
  rst_idle_a: assert property (
    @(posedge clk) disable iff (1'b0)
    !rst_n |=> !up_data_oe && !up_irq_oe && !core_req.rd && !core_req.wr)
    else $error("port not idle after reset");

  cov_rd_c: cover property (rd_act ##1 rd_act ##1 up_data_oe);
  cov_wr_c: cover property (core_req.wr);
  cov_irq_c: cover property (!up_irq_oe ##1 up_irq_oe);
  cov_split_c: cover property (mode == HPP_MODE_SPLIT && core_req.wr);
  cov_comb_rd_c: cover property (mode == HPP_MODE_COMBINED && core_req.rd ##1 up_data_oe);
endmodule

// [verification/hpp_mem_model.sv]
// register and memory space model behind the host processor port
`timescale 1ns/100ps
module hpp_mem_model
  import hpp_pkg::*;
(
  // clock
  input  wire logic        clk,
  // access from the port
  input  wire hpp_req_t    req,
  output logic      [15:0] rdata
);
  logic [15:0] mem_ff [4096];
  // reads are combinational so the port sees data in the cycle it asks
  always_ff @(posedge clk) begin
    if (req.wr) mem_ff[req.addr] <= req.wdata;
  end
  assign rdata = mem_ff[req.addr];
endmodule

// [verification/testbench.sv]
// self-checking bench for the host processor port
`timescale 1ns/100ps
module testbench;
  import hpp_pkg::*;
  logic        clk = 0, rst_n = 0, cs_n = 1, rnw = 1, ord = 0, drv_en = 0;
  logic        pend = 0, pend_q = 0, live = 0, oe, oe_q = 0, irq_out, irq_oe;
  hpp_mode_t   mode = HPP_MODE_COMBINED;
  logic [11:0] addr = 12'h000, a;
  logic [15:0] drv = 16'h0000, din, dout, rdat;
  logic [31:0] rnd;
  hpp_req_t    req;
  logic [15:0] exp_mem [4096];
  logic [15:0] q [$];
  integer      seed = 32'he5c9c58c;
  int          mismatches = 0, n_compared = 0, cyc = 0, i;
  always #5 clk = ~clk;
  // a released bus shows the inverse of its last value, never a held copy
  assign din = oe ? dout : (drv_en ? drv : ~drv);
  hpp_port uut (.clk(clk), .rst_n(rst_n), .mode(mode), .up_addr(addr), .up_data_in(din),
    .up_data_out(dout), .up_data_oe(oe), .up_cs_n(cs_n), .up_rnw_or_wr_n(rnw), .up_oe_or_rd_n(ord),
    .up_irq_out(irq_out), .up_irq_oe(irq_oe), .core_req(req), .core_rdata(rdat), .core_irq_pend(pend));
  hpp_mem_model mem (.clk(clk), .req(req), .rdata(rdat));
  task automatic chk(logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (e !== g) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one access: cs is the chip-select level, hold the edges the strobe stays active
  task automatic acc(bit w, bit cs, logic [11:0] ad, logic [15:0] d, int hold);
    @(posedge clk);
    #1;
    cs_n = cs;
    addr = ad;
    drv = d;
    drv_en = w;
    rnw = ~w;
    ord = (mode == HPP_MODE_SPLIT) ? w : 1'b0;
    if (!cs && w) exp_mem[ad] = d;
    if (!cs && !w) q.push_back(exp_mem[ad]);
    repeat (hold) @(posedge clk);
    #1;
    cs_n = 1;
    rnw = 1;
    ord = (mode == HPP_MODE_SPLIT);
    drv_en = 0;
  endtask
  // output watcher: each rise of the data enable must answer the oldest pending read
  always @(posedge clk) begin
    cyc++;
    live <= rst_n;
    pend_q <= pend;
    oe_q <= oe;
    if (live && rst_n) begin
      chk({15'h0, pend_q}, {15'h0, irq_oe});
      chk(16'h0, {15'h0, irq_out});
    end
    if (oe && !oe_q) chk(q.size() ? q.pop_front() : ~dout, dout);
    if (cyc > 2000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1;
    for (i = 0; i < 24; i++) begin
      if (i == 12) begin
        @(posedge clk);
        #1;
        mode = HPP_MODE_SPLIT;
        ord = 1;
      end
      rnd = $random(seed);
      a = (i % 2) ? 12'hfff - 12'(i) : 12'(i);
      pend = rnd[16];
      acc(1, 0, a, rnd[15:0], 1 + i % 3);
      acc(0, 0, a, 16'h0, 3);
      acc(1, 1, a, ~rnd[15:0], 1);
      acc(0, 1, a, 16'h0, 3);
      acc(0, 0, a, 16'h0, 3);
    end
    repeat (4) @(posedge clk);
    chk(16'h0, 16'(q.size()));
    final_report();
  end
endmodule
